// [verilog/txser_cfg.svh]
// Purpose: Register map, field positions, reset values and timing counts of the serializer.
// Assumes: Byte-wide register port, 16-bit register address, 250 MHz clock.
// Notes:   Definitions only; included by its bare name.
`ifndef TXSER_CFG_SVH
`define TXSER_CFG_SVH

// Register addresses on the register port.
`define TXS_ADDR_CTRL     16'h00A9
`define TXS_ADDR_TIMING   16'h00AA
`define TXS_ADDR_DATA     16'h00AB
`define TXS_ADDR_RATEL    16'h00AC
`define TXS_ADDR_RATEH    16'h00AD
`define TXS_ADDR_LVL      16'h00CE
`define TXS_ADDR_CAP_HI   16'h400C
`define TXS_ADDR_CAP_LO   16'h400D
`define TXS_ADDR_TRIM     16'h4012

// Field positions in the serializer control register.
`define TXS_CTRL_EN       0
`define TXS_CTRL_AMP_HOLD 1
`define TXS_CTRL_DIV_HOLD 2
`define TXS_CTRL_LC_HOLD  3
`define TXS_CTRL_FSK      4
`define TXS_CTRL_FDEV     5
`define TXS_CTRL_EOD_LO   6
`define TXS_CTRL_EOD_HI   7

// Field position of the bias boost bit in the trim register.
`define TXS_TRIM_BOOST    4

// End-of-data action codes.
`define TXS_EOD_OFF       2'b00
`define TXS_EOD_REPEAT    2'b01
`define TXS_EOD_ZEROS     2'b10
`define TXS_EOD_ONES      2'b11

// Reset values.
`define TXS_RST_BYTE      8'h00
`define TXS_RST_CAP       9'h000

// Warm-up time of the divider and oscillator before the first symbol.
`define TXS_CLK_MHZ       250
`define TXS_WARM_NS       1000
`define TXS_WARM_CYC      ((`TXS_WARM_NS * `TXS_CLK_MHZ + 999) / 1000)

`endif

// [verilog/txser_pkg.sv]
// Purpose: Types shared by the serializer files.
// Assumes: Nothing beyond SystemVerilog.
// Notes:   Constants live in txser_cfg.svh.
package txser_pkg;

  // Byte as carried on the register port and through the FIFO.
  typedef logic [7:0] txser_byte_t;

  // Serializer sequencing states.
  typedef enum logic [1:0] {
    TXS_IDLE,
    TXS_WARM,
    TXS_RUN,
    TXS_DRAIN
  } txser_state_e;

endpackage

// [verilog/txser_fifo.sv]
// Purpose: Synchronous FIFO with valid/ready on both sides.
// Assumes: Single clock, synchronous active-high reset, DEPTH a power of two.
// Notes:   No push when full, no pop when empty; both may happen in one cycle.
`timescale 1ns/1ps
`default_nettype none

module txser_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset.
  input  wire logic             ref_clk_in,
  input  wire logic             srst_in,
  // Fill side.
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // Drain side.
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  import txser_pkg::*;

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic             push;
  logic             pop;

  // Handshakes come straight from the fill count.
  assign in_ready_out  = (count_ff != (AW+1)'(DEPTH));
  assign out_valid_out = (count_ff != '0);
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;
  assign out_data_out  = mem_ff[rd_ptr_ff];

  // Storage array, written on push only.
  always_ff @(posedge ref_clk_in)
  begin
    if (push)
    begin
      mem_ff[wr_ptr_ff] <= in_data_in;
    end
  end

  // Pointers and fill count.
  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      if (push && !pop)
      begin
        count_ff <= count_ff + 1'b1;
      end
      else if (pop && !push)
      begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end

endmodule // txser_fifo

`default_nettype wire

// [verilog/txser_top.sv]
// Purpose: Transmit serializer with amplifier, divider and oscillator control registers.
// Assumes: Byte-wide register port driven from logic on ref_clk_in; 250 MHz clock.
// Notes:   Symbol groups go out least significant symbol first.
`timescale 1ns/1ps
`default_nettype none

`include "txser_cfg.svh"

module txser_top #(
  parameter int          FIFO_DEPTH = 32,
  parameter logic [6:0]  DEV_CODE   = 7'h7F
) (
  // Clock and reset.
  input  wire logic                 ref_clk_in,
  input  wire logic                 srst_in,
  // Register port.
  input  wire logic [15:0]          reg_addr_in,
  input  wire logic                 reg_wr_en_in,
  input  wire logic                 reg_rd_en_in,
  input  wire txser_pkg::txser_byte_t reg_wdata_in,
  output txser_pkg::txser_byte_t    reg_rdata_out,
  output logic                      reg_rvalid_out,
  // Data handshake.
  output logic                      hold_empty_out,
  output logic                      new_data_pulse_out,
  // Analog controls.
  output logic                      amp_on_out,
  output logic [4:0]                amp_slices_out,
  output logic [2:0]                amp_bias_out,
  output logic                      amp_boost_out,
  output logic [8:0]                amp_cap_out,
  output logic                      divider_on_out,
  output logic                      lc_osc_on_out,
  output logic [6:0]                freq_dev_out,
  output logic                      ser_data_out,
  output logic                      ser_busy_out
);
  import txser_pkg::*;

  localparam int WARM_CYC = `TXS_WARM_CYC;

  txser_byte_t  ctrl_ff;
  txser_byte_t  timing_ff;
  txser_byte_t  rate_l_ff;
  logic [6:0]   rate_h_ff;
  txser_byte_t  lvl_ff;
  logic [8:0]   cap_ff;
  logic         boost_ff;
  txser_byte_t  hold_ff;
  logic         hold_full_ff;
  logic         wr_pulse_ff;
  txser_byte_t  rdata_ff;
  logic         rvalid_ff;
  txser_state_e state_ff;
  logic [15:0]  warm_cnt_ff;
  logic [18:0]  sym_cnt_ff;
  logic [2:0]   bit_idx_ff;
  txser_byte_t  shift_ff;
  txser_byte_t  last_grp_ff;
  logic [4:0]   slices_ff;
  logic [5:0]   edge_cnt_ff;
  logic         amp_on_ff;
  logic         div_on_ff;
  logic         lc_on_ff;
  logic [6:0]   dev_ff;
  logic         fifo_in_ready;
  logic         fifo_out_valid;
  txser_byte_t  fifo_out_data;
  logic         fifo_pop;
  logic         wr_data;
  logic         sym_tick;
  logic         grp_end;
  logic         edge_tick;
  logic [4:0]   slice_target;
  logic [1:0]   eod;

  // Symbol period in system clocks: rate times divider, a rate of zero acts as one.
  function automatic logic [18:0] sym_period(input logic [14:0] rate, input logic [2:0] div);
    logic [14:0] r;
    r = (rate == 15'h0000) ? 15'h0001 : rate;
    return 19'(r * ({1'b0, div} + 4'h1));
  endfunction

  // Index of the last symbol of a group; width field 0 is treated as two symbols.
  function automatic logic [2:0] grp_last(input logic [2:0] width);
    return (width == 3'h0) ? 3'h1 : width;
  endfunction

  // Clocks between two slice steps of an edge ramp.
  function automatic logic [5:0] edge_period(input logic [2:0] div, input logic [1:0] et);
    return 6'(({3'b000, div} + 6'h01) * ({4'h0, et} + 6'h01));
  endfunction

  assign eod     = ctrl_ff[`TXS_CTRL_EOD_HI:`TXS_CTRL_EOD_LO];
  assign wr_data = reg_wr_en_in && (reg_addr_in == `TXS_ADDR_DATA);

  // Register writes; each register has its own documented address.
  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      ctrl_ff   <= `TXS_RST_BYTE;
      timing_ff <= `TXS_RST_BYTE;
      rate_l_ff <= `TXS_RST_BYTE;
      rate_h_ff <= 7'h00;
      lvl_ff    <= `TXS_RST_BYTE;
      cap_ff    <= `TXS_RST_CAP;
      boost_ff  <= 1'b0;
      hold_ff   <= `TXS_RST_BYTE;
    end
    else if (reg_wr_en_in)
    begin
      case (reg_addr_in)
        `TXS_ADDR_CTRL:   ctrl_ff   <= reg_wdata_in;
        `TXS_ADDR_TIMING: timing_ff <= reg_wdata_in;
        `TXS_ADDR_DATA:   hold_ff   <= reg_wdata_in;
        `TXS_ADDR_RATEL:  rate_l_ff <= reg_wdata_in;
        `TXS_ADDR_RATEH:  rate_h_ff <= reg_wdata_in[6:0];
        `TXS_ADDR_LVL:    lvl_ff    <= reg_wdata_in;
        `TXS_ADDR_CAP_HI: cap_ff[8] <= reg_wdata_in[0];
        `TXS_ADDR_CAP_LO: cap_ff[7:0] <= reg_wdata_in;
        `TXS_ADDR_TRIM:   boost_ff  <= reg_wdata_in[`TXS_TRIM_BOOST];
        default:          ctrl_ff   <= ctrl_ff;
      endcase
    end
  end

  // Register reads answer one cycle later; unmapped addresses read zero.
  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      rdata_ff  <= `TXS_RST_BYTE;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      rvalid_ff <= reg_rd_en_in;
      if (reg_rd_en_in)
      begin
        case (reg_addr_in)
          `TXS_ADDR_CTRL:   rdata_ff <= ctrl_ff;
          `TXS_ADDR_TIMING: rdata_ff <= timing_ff;
          `TXS_ADDR_DATA:   rdata_ff <= hold_ff;
          `TXS_ADDR_RATEL:  rdata_ff <= rate_l_ff;
          `TXS_ADDR_RATEH:  rdata_ff <= {1'b0, rate_h_ff};
          `TXS_ADDR_LVL:    rdata_ff <= lvl_ff;
          `TXS_ADDR_CAP_HI: rdata_ff <= {7'h00, cap_ff[8]};
          `TXS_ADDR_CAP_LO: rdata_ff <= cap_ff[7:0];
          `TXS_ADDR_TRIM:   rdata_ff <= {3'b000, boost_ff, 4'h0};
          default:          rdata_ff <= `TXS_RST_BYTE;
        endcase
      end
    end
  end

  // Holding byte: a write fills it, a move into the FIFO empties it; a new write wins.
  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      hold_full_ff <= 1'b0;
      wr_pulse_ff  <= 1'b0;
    end
    else
    begin
      wr_pulse_ff <= wr_data;
      if (wr_data)
      begin
        hold_full_ff <= 1'b1;
      end
      else if (fifo_in_ready)
      begin
        hold_full_ff <= 1'b0;
      end
    end
  end

  // Queue between the holding byte and the shifter; a full queue stalls the holding byte.
  txser_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_in    (ref_clk_in),
    .srst_in       (srst_in),
    .in_valid_in   (hold_full_ff),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (hold_ff),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (fifo_pop),
    .out_data_out  (fifo_out_data)
  );

  // Symbol timing and group boundary decode.
  assign sym_tick = (state_ff == TXS_RUN) &&
                    (sym_cnt_ff >= sym_period({rate_h_ff, rate_l_ff}, timing_ff[2:0]) - 19'h1);
  assign grp_end  = sym_tick && (bit_idx_ff == grp_last(timing_ff[7:5]));
  assign fifo_pop = fifo_out_valid &&
                    (((state_ff == TXS_WARM) && (warm_cnt_ff == 16'(WARM_CYC - 1))) || grp_end);

  // Sequencer: warm up, run groups, drain the amplifier ramp, return to idle.
  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in || !ctrl_ff[`TXS_CTRL_EN])
    begin
      state_ff    <= TXS_IDLE;
      warm_cnt_ff <= 16'h0000;
    end
    else
    begin
      case (state_ff)
        TXS_IDLE:
        begin
          warm_cnt_ff <= 16'h0000;
          if (fifo_out_valid)
          begin
            state_ff <= TXS_WARM;
          end
        end
        TXS_WARM:
        begin
          warm_cnt_ff <= warm_cnt_ff + 16'h0001;
          if (fifo_pop)
          begin
            state_ff <= TXS_RUN;
          end
        end
        TXS_RUN:
        begin
          if (grp_end && !fifo_out_valid && (eod == `TXS_EOD_OFF))
          begin
            state_ff <= TXS_DRAIN;
          end
        end
        TXS_DRAIN:
        begin
          if (slices_ff == 5'h00 || ctrl_ff[`TXS_CTRL_AMP_HOLD])
          begin
            state_ff <= TXS_IDLE;
          end
        end
        default: state_ff <= TXS_IDLE;
      endcase
    end
  end

  // Shifter: loads a group from the queue, or the end-of-data filler when it runs dry.
  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in || state_ff == TXS_IDLE)
    begin
      sym_cnt_ff  <= 19'h00000;
      bit_idx_ff  <= 3'h0;
      shift_ff    <= `TXS_RST_BYTE;
      last_grp_ff <= `TXS_RST_BYTE;
    end
    else if (fifo_pop)
    begin
      sym_cnt_ff  <= 19'h00000;
      bit_idx_ff  <= 3'h0;
      shift_ff    <= fifo_out_data;
      last_grp_ff <= fifo_out_data;
    end
    else if (grp_end)
    begin
      sym_cnt_ff <= 19'h00000;
      bit_idx_ff <= 3'h0;
      case (eod)
        `TXS_EOD_REPEAT: shift_ff <= last_grp_ff;
        `TXS_EOD_ZEROS:  shift_ff <= 8'h00;
        `TXS_EOD_ONES:   shift_ff <= 8'hFF;
        default:         shift_ff <= 8'h00;
      endcase
    end
    else if (sym_tick)
    begin
      sym_cnt_ff <= 19'h00000;
      bit_idx_ff <= bit_idx_ff + 3'h1;
      shift_ff   <= {1'b0, shift_ff[7:1]};
    end
    else if (state_ff == TXS_RUN)
    begin
      sym_cnt_ff <= sym_cnt_ff + 19'h00001;
    end
  end

  // Amplifier target: full slice count while a one is sent in OOK, or throughout FSK.
  assign slice_target = ((state_ff == TXS_RUN) &&
                         (ctrl_ff[`TXS_CTRL_FSK] || shift_ff[0])) ? lvl_ff[7:3] : 5'h00;
  assign edge_tick    = (edge_cnt_ff >= edge_period(timing_ff[2:0], timing_ff[4:3]) - 6'h01);

  // Edge ramp: one slice per edge step toward the target; hold-on loads the count as is.
  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      slices_ff   <= 5'h00;
      edge_cnt_ff <= 6'h00;
    end
    else if (ctrl_ff[`TXS_CTRL_AMP_HOLD])
    begin
      slices_ff   <= lvl_ff[7:3];
      edge_cnt_ff <= 6'h00;
    end
    else if (slices_ff == slice_target)
    begin
      edge_cnt_ff <= 6'h00;
    end
    else if (edge_tick)
    begin
      edge_cnt_ff <= 6'h00;
      slices_ff   <= (slices_ff < slice_target) ? slices_ff + 5'h01 : slices_ff - 5'h01;
    end
    else
    begin
      edge_cnt_ff <= edge_cnt_ff + 6'h01;
    end
  end

  // Power scheduling: divider and oscillator outside idle or when held on, amplifier while driving or when held on.
  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      amp_on_ff <= 1'b0;
      div_on_ff <= 1'b0;
      lc_on_ff  <= 1'b0;
    end
    else
    begin
      amp_on_ff <= ctrl_ff[`TXS_CTRL_AMP_HOLD] || (slices_ff != 5'h00) ||
                   (slice_target != 5'h00);
      div_on_ff <= ctrl_ff[`TXS_CTRL_DIV_HOLD] || (state_ff != TXS_IDLE);
      lc_on_ff  <= ctrl_ff[`TXS_CTRL_LC_HOLD] || (state_ff != TXS_IDLE);
    end
  end

  // Deviation bus: forced, or following the data in FSK, else centred.
  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      dev_ff <= 7'h00;
    end
    else if (ctrl_ff[`TXS_CTRL_FDEV])
    begin
      dev_ff <= DEV_CODE;
    end
    else if (ctrl_ff[`TXS_CTRL_FSK] && (state_ff == TXS_RUN) && shift_ff[0])
    begin
      dev_ff <= DEV_CODE;
    end
    else
    begin
      dev_ff <= 7'h00;
    end
  end

  // Output wiring; every output comes from a flip-flop, hold_empty_out and ser_busy_out through logic.
  assign reg_rdata_out      = rdata_ff;
  assign reg_rvalid_out     = rvalid_ff;
  assign hold_empty_out     = !hold_full_ff;
  assign new_data_pulse_out = wr_pulse_ff;
  assign amp_on_out         = amp_on_ff;
  assign amp_slices_out     = slices_ff;
  assign amp_bias_out       = lvl_ff[2:0];
  assign amp_boost_out      = boost_ff;
  assign amp_cap_out        = cap_ff;
  assign divider_on_out     = div_on_ff;
  assign lc_osc_on_out      = lc_on_ff;
  assign freq_dev_out       = dev_ff;
  assign ser_data_out       = shift_ff[0];
  assign ser_busy_out       = (state_ff != TXS_IDLE);

  // Checks on the behaviour above.
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);

  a_eod_shutdown: assert property (
    (grp_end && !fifo_out_valid && eod == `TXS_EOD_OFF && ctrl_ff[0]) |=> state_ff == TXS_DRAIN)
    else $error("No shutdown after the last group.");
  a_eod_repeat: assert property (
    (grp_end && !fifo_out_valid && eod == `TXS_EOD_REPEAT && ctrl_ff[0])
    |=> shift_ff == $past(last_grp_ff))
    else $error("Last group not repeated.");
  a_eod_fill: assert property (
    (grp_end && !fifo_out_valid && eod[1] && ctrl_ff[0]) |=> shift_ff == {8{$past(eod[0])}})
    else $error("Filler pattern wrong.");
  a_force_dev: assert property (
    ctrl_ff[`TXS_CTRL_FDEV] |=> freq_dev_out == DEV_CODE)
    else $error("Forced deviation missing.");
  a_ook_no_dev: assert property (
    (!ctrl_ff[`TXS_CTRL_FDEV] && !ctrl_ff[`TXS_CTRL_FSK]) |=> freq_dev_out == 7'h00)
    else $error("Deviation in OOK mode.");
  a_hold_power: assert property (
    (ctrl_ff[`TXS_CTRL_LC_HOLD] && ctrl_ff[`TXS_CTRL_DIV_HOLD]) |=> lc_osc_on_out && divider_on_out)
    else $error("Held unit not powered.");
  a_amp_pass: assert property (
    ctrl_ff[`TXS_CTRL_AMP_HOLD] |=> amp_on_out && amp_slices_out == $past(lvl_ff[7:3]))
    else $error("Slice count not passed through.");
  a_idle_off: assert property (
    (state_ff == TXS_IDLE && !ctrl_ff[`TXS_CTRL_LC_HOLD] && !ctrl_ff[`TXS_CTRL_DIV_HOLD])
    |=> !lc_osc_on_out && !divider_on_out)
    else $error("Units powered while idle.");
  a_edge_step: assert property (
    !ctrl_ff[`TXS_CTRL_AMP_HOLD] |=> (amp_slices_out == $past(amp_slices_out)) ||
      (amp_slices_out == $past(amp_slices_out) + 5'h01) ||
      (amp_slices_out == $past(amp_slices_out) - 5'h01))
    else $error("Slice count jumped.");
  a_data_write: assert property (
    wr_data |=> !hold_empty_out && new_data_pulse_out ##1 !new_data_pulse_out || $past(wr_data))
    else $error("Data write handshake wrong.");
  a_cap_upper: assert property (
    (reg_rd_en_in && reg_addr_in == `TXS_ADDR_CAP_HI) |=> reg_rvalid_out && reg_rdata_out[7:1] == 7'h00)
    else $error("Upper capacitance bits not zero.");
  a_disabled_idle: assert property (
    !ctrl_ff[`TXS_CTRL_EN] |=> state_ff == TXS_IDLE)
    else $error("Serializer active while disabled.");

  c_run: cover property (state_ff == TXS_WARM ##1 state_ff == TXS_RUN);
  c_drain: cover property (state_ff == TXS_DRAIN ##1 state_ff == TXS_IDLE);
  c_full: cover property (hold_full_ff && !fifo_in_ready);

endmodule // txser_top

`default_nettype wire

// [testbench/txser_amp_model.sv]
// Purpose: Behavioural model of the amplifier and oscillator.
// Assumes: Controls come straight from the serializer outputs.
// Notes:   An unpowered stage gives no drive and no deviation.
`timescale 1ns/1ps
`default_nettype none

module txser_amp_model (
  // Controls from the serializer.
  input  wire logic       amp_on_in,
  input  wire logic [4:0] slices_in,
  input  wire logic       lc_on_in,
  input  wire logic [6:0] dev_in,
  // Modelled carrier state.
  output logic [4:0]      rf_drive_out,
  output logic [6:0]      rf_dev_out
);
  // Drive and deviation exist only while the stage is powered.
  assign rf_drive_out = amp_on_in ? slices_in : 5'h00;
  assign rf_dev_out   = lc_on_in ? dev_in : 7'h00;
endmodule // txser_amp_model

`default_nettype wire

// [testbench/test_tx_serializer_amp_control.sv]
// Purpose: Self-checking bench for the serializer and amplifier controls.
// Assumes: Inputs change at the falling edge of a 4 ns clock.
// Notes:   Read answers are compared by a monitor against a queue.
`timescale 1ns/1ps
`default_nettype none

`include "txser_cfg.svh"

module test_tx_serializer_amp_control;
  import txser_pkg::*;
  localparam logic [6:0] DEV = 7'h7F;
  // Bench signals.
  logic        ref_clk_in = 1'b0;
  logic        srst_in    = 1'b1;
  logic [15:0] addr       = 16'h0000;
  logic        wr_en      = 1'b0;
  logic        rd_en      = 1'b0;
  txser_byte_t wdata      = 8'h00;
  txser_byte_t rdata;
  logic        rvalid, empty, pulse, amp_on, boost, div_on, lc_on, sdata, busy;
  logic [4:0]  slices, drive;
  logic [2:0]  bias;
  logic [8:0]  cap;
  logic [6:0]  dev, rf_dev;
  logic [5:0]  prv        = 6'h00;
  logic        ramp_chk   = 1'b0;
  txser_byte_t exp_q[$];
  txser_byte_t lvl;
  int          fails      = 0;
  int          n_tests    = 0;
  int          cyc        = 0;
  int          seed       = 5;
  int          k;

  // Free-running clock.
  initial
  begin
    forever #2 ref_clk_in = ~ref_clk_in;
  end

  // Device under test.
  txser_top u_txser_top (
    .ref_clk_in(ref_clk_in), .srst_in(srst_in),
    .reg_addr_in(addr), .reg_wr_en_in(wr_en), .reg_rd_en_in(rd_en),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .hold_empty_out(empty), .new_data_pulse_out(pulse),
    .amp_on_out(amp_on), .amp_slices_out(slices), .amp_bias_out(bias),
    .amp_boost_out(boost), .amp_cap_out(cap), .divider_on_out(div_on),
    .lc_osc_on_out(lc_on), .freq_dev_out(dev), .ser_data_out(sdata),
    .ser_busy_out(busy)
  );

  // Analog far side.
  txser_amp_model u_txser_amp_model (
    .amp_on_in(amp_on), .slices_in(slices), .lc_on_in(lc_on),
    .dev_in(dev), .rf_drive_out(drive), .rf_dev_out(rf_dev)
  );

  // Compares one value and counts the outcome.
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      fails++;
    end
  endtask

  // One write; the trailing idle edge leaves one idle clock cycle between strobes.
  task automatic wr(input logic [15:0] a, input txser_byte_t d);
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    @(negedge ref_clk_in);
    wr_en = 1'b0;
    @(negedge ref_clk_in);
  endtask

  // One read; the expected byte is queued for the monitor.
  task automatic rd(input logic [15:0] a, input txser_byte_t e);
    addr = a;
    exp_q.push_back(e);
    rd_en = 1'b1;
    @(negedge ref_clk_in);
    rd_en = 1'b0;
    @(negedge ref_clk_in);
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Read answers against the queue, and slice steps of at most one.
  always @(negedge ref_clk_in)
  begin
    if (rvalid === 1'b1)
      chk({1'b0, rdata}, {1'b0, exp_q.pop_front()});
    if (ramp_chk && ({1'b0, slices} > prv + 6'd1 || prv > {1'b0, slices} + 6'd1))
      chk(9'h001, 9'h000);
    prv <= {1'b0, slices};
  end

  // Cuts a hang short.
  always @(posedge ref_clk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      end_of_test();
    end
  end

  // Main sequence.
  initial
  begin
    idle(12);
    srst_in = 1'b0;
    // Reset values and an unmapped address.
    rd(`TXS_ADDR_CTRL, 8'h00);
    rd(`TXS_ADDR_LVL, 8'h00);
    rd(`TXS_ADDR_CAP_HI, 8'h00);
    rd(`TXS_ADDR_CAP_LO, 8'h00);
    rd(`TXS_ADDR_TRIM, 8'h00);
    rd(16'h1234, 8'h00);
    $display("test reset done");
    // Level fields, capacitance word and bias boost.
    lvl = $random(seed) | 8'h80;
    wr(`TXS_ADDR_LVL, lvl);
    rd(`TXS_ADDR_LVL, lvl);
    chk({6'h00, bias}, {6'h00, lvl[2:0]});
    wr(`TXS_ADDR_CAP_HI, 8'hFF);
    wr(`TXS_ADDR_CAP_LO, lvl);
    rd(`TXS_ADDR_CAP_HI, 8'h01);
    chk(cap, {1'b1, lvl});
    wr(`TXS_ADDR_TRIM, 8'h10);
    rd(`TXS_ADDR_TRIM, 8'h10);
    chk({8'h00, boost}, 9'h001);
    // Timing and upper rate registers read back, then return to their fastest settings.
    wr(`TXS_ADDR_TIMING, 8'hE3);
    rd(`TXS_ADDR_TIMING, 8'hE3);
    wr(`TXS_ADDR_TIMING, 8'h00);
    wr(`TXS_ADDR_RATEH, 8'hFF);
    rd(`TXS_ADDR_RATEH, 8'h7F);
    wr(`TXS_ADDR_RATEH, 8'h00);
    $display("test fields done");
    // Hold-on bits and forced deviation with the serializer off.
    wr(`TXS_ADDR_CTRL, 8'h2E);
    idle(2);
    chk({6'h00, lc_on, div_on, amp_on}, 9'h007);
    chk({4'h0, drive}, {4'h0, lvl[7:3]});
    chk({2'b00, rf_dev}, {2'b00, DEV});
    wr(`TXS_ADDR_CTRL, 8'h00);
    $display("test hold done");
    // Fill buffer and holding byte until the flag stays low.
    for (k = 0; k <= 32; k++)
    begin
      // The pulse stands only in the cycle after the write, so it is looked at there.
      addr  = `TXS_ADDR_DATA;
      wdata = 8'hFF;
      wr_en = 1'b1;
      @(negedge ref_clk_in);
      chk({7'h00, pulse, empty}, 9'h002);
      wr_en = 1'b0;
      @(negedge ref_clk_in);
      chk({8'h00, empty}, {8'h00, k != 32});
      idle(1);
    end
    idle(3);
    chk({8'h00, empty}, 9'h000);
    $display("test fill done");
    // Each end action once the data has run out; the last one runs in OOK mode.
    // The wait covers the warm-up, which a restart from idle goes through again.
    for (k = 0; k < 4; k++)
    begin
      ramp_chk = 1'b1;
      wr(`TXS_ADDR_CTRL, {k[1:0], 1'b0, k != 3, 3'b000, 1'b1});
      if (k > 0)
        wr(`TXS_ADDR_DATA, 8'hFF);
      for (int w = 0; w < 1000 && empty !== 1'b1; w++)
        idle(1);
      idle(320);
      if (k == 0)
        chk({5'h00, busy, lc_on, div_on, amp_on}, 9'h000);
      else
      begin
        chk({8'h00, sdata}, {8'h00, k != 2});
        chk({2'b00, dev}, (k == 1) ? {2'b00, DEV} : 9'h000);
        chk({4'h0, drive}, {4'h0, lvl[7:3]});
      end
    end
    ramp_chk = 1'b0;
    wr(`TXS_ADDR_CTRL, 8'h00);
    chk({8'h00, busy}, 9'h000);
    $display("test stream done");
    end_of_test();
  end
endmodule // test_tx_serializer_amp_control

`default_nettype wire
